/* rtl/tec_consts.svh */
// register offsets, field positions, reset values and codes of the event counter
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH
`define TEC_OFS_COUNT      4'h0
`define TEC_OFS_CTRL       4'h4
`define TEC_OFS_PRELOAD    4'h8
`define TEC_OFS_STATUS     4'hC
`define TEC_CTRL_RESET     8'h08
`define TEC_MODE_HI        7
`define TEC_MODE_LO        6
`define TEC_SRC_BIT        5
`define TEC_EN_BIT         4
`define TEC_EDGE_BIT       3
`define TEC_PSC_HI         2
`define TEC_MODE_NONE      2'h0
`define TEC_MODE_EVENT     2'h1
`define TEC_MODE_TIMER     2'h2
`define TEC_MODE_PULSE     2'h3
`define TEC_FULL           8'hFF
`define TEC_ZERO8          8'h00
`define TEC_ONE8           8'h01
`define TEC_PSC_ONES       7'h7F
`endif

/* rtl/tec_pkg.sv */
// types of the event counter
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_CAP_IDLE,
    TEC_CAP_ARMED,
    TEC_CAP_RUN
  } tec_cap_t;
endpackage

/* rtl/tec_prescaler.sv */
// power of two prescaler producing a one-cycle tick enable
`include "tec_consts.svh"
module tec_prescaler
  import tec_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       clear,
  input  wire logic [2:0] rate,
  output logic            tick
);
  logic [6:0] div_q;
  logic [6:0] mask;

  assign mask = 7'(`TEC_PSC_ONES >> (3'h7 - rate));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 7'h00;
    end else if (clear) begin
      div_q <= 7'h00;
    end else if (clk_en) begin
      div_q <= (div_q & mask) == mask ? 7'h00 : div_q + 7'h01;
    end
  end

  // a tick every 2^rate source pulses
  assign tick = clk_en && ((div_q & mask) == mask);
endmodule // tec_prescaler

/* rtl/tec_preload_mem.sv */
// preload storage with registered read port, left unreset on purpose
`include "tec_consts.svh"
module tec_preload_mem
  import tec_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data
);
  logic [7:0] word_q;

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      word_q <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    rd_data <= wr_en ? wr_data : word_q;
  end
endmodule // tec_preload_mem

/* rtl/tec_counter.sv */
// 8-bit timer / event counter with Wishbone register access
`include "tec_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE_01: control bits 7:6 pick mode: none, event, interval timer, pulse capture.
// RULE_02: timer and capture modes count internal ticks; event mode counts pin edges.
// RULE_03: control bit 5 picks system clock (0) or slow crystal clock (1).
// RULE_04: enabled pulse width modulator forces the system clock as prescaler input.
// RULE_05: control bit 4 runs the counter; cleared, the count holds.
// RULE_06: control bits 2:0 divide the prescaler input by two to that power.
// RULE_07: external pin edges are never divided by the prescaler.
// RULE_08: event mode counts rising edges when bit 3 is 0, falling when 1.
// RULE_09: capture mode edge 0 starts on fall, stops on rise; 1 the reverse.
// RULE_10: count grows by exactly one per selected tick or edge while enabled.
// RULE_11: passing FFH raises interrupt request, reloads preload, keeps counting.
// RULE_12: preload write while disabled is copied at once into the count.
// RULE_13: preload write while enabled waits for the next overflow reload.
// RULE_14: reading the timer register returns the live count.
// RULE_15: preload has no reset value; unknown until written.
// RULE_16: software clears preload to zero for the full 256-count range.
// RULE_17: in capture mode the enable only arms; first active edge starts counting.
// RULE_18: capture ends at idle level; hardware clears enable, later edges ignored.
// RULE_19: event mode keeps counting during sleep; overflow signals wake-up.
// RULE_20: timer pin is synchronised and edge detected, one event per transition.
module tec_counter
  import tec_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        sys_tick,
  input  wire logic        low_speed_crystal_clock,
  input  wire logic        pwm_enabled,
  input  wire logic        ext_timer_input,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             timer_irq,
  output logic             wake_req
);
  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] count_q;
  logic [7:0] ctrl_q;
  logic [7:0] preload_rd;
  logic       ovf_flag_q;
  logic       pin_s1_q;
  logic       pin_s2_q;
  logic       pin_s3_q;
  logic       slow_s1_q;
  logic       slow_s2_q;
  logic       slow_s3_q;
  tec_cap_t   cap_q;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
  wire        wr_count  = bus_wr && (wb_adr_i == `TEC_OFS_COUNT);
  wire        wr_ctrl   = bus_wr && (wb_adr_i == `TEC_OFS_CTRL);
  wire        wr_pre    = bus_wr && (wb_adr_i == `TEC_OFS_PRELOAD);
  wire        wr_stat   = bus_wr && (wb_adr_i == `TEC_OFS_STATUS);
  wire  [7:0] wr_byte   = wb_dat_i[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // control fields
  wire  [1:0] mode      = ctrl_q[`TEC_MODE_HI:`TEC_MODE_LO]; // RULE_01
  wire        src_slow  = ctrl_q[`TEC_SRC_BIT];
  wire        enable    = ctrl_q[`TEC_EN_BIT];
  wire        edge_sel  = ctrl_q[`TEC_EDGE_BIT];
  wire  [2:0] rate      = ctrl_q[`TEC_PSC_HI:0];
  wire        internal  = (mode == `TEC_MODE_TIMER) || (mode == `TEC_MODE_PULSE); // RULE_02

  //////////////////////////////////////////////////////////////////////////////
  // pin and slow clock synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q  <= 1'b0;
      pin_s2_q  <= 1'b0;
      pin_s3_q  <= 1'b0;
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      slow_s3_q <= 1'b0;
    end else begin
      pin_s1_q  <= ext_timer_input; // RULE_20
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      slow_s1_q <= low_speed_crystal_clock;
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
    end
  end

  wire        pin_rise  = pin_s2_q && !pin_s3_q; // RULE_20
  wire        pin_fall  = !pin_s2_q && pin_s3_q; // RULE_20
  wire        slow_tick = slow_s3_q && !slow_s2_q;
  // edge 0 selects rising for events, falling as capture start
  wire        evt_edge  = edge_sel ? pin_fall : pin_rise; // RULE_08
  wire        cap_start = edge_sel ? pin_rise : pin_fall; // RULE_09
  wire        cap_stop  = edge_sel ? pin_fall : pin_rise; // RULE_09

  //////////////////////////////////////////////////////////////////////////////
  // prescaler
  wire        use_slow  = src_slow && !pwm_enabled; // RULE_03 RULE_04
  wire        psc_src   = use_slow ? slow_tick : sys_tick;
  logic       psc_tick;

  tec_prescaler u_psc (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (psc_src && internal),
    .clear  (wr_ctrl),
    .rate   (rate), // RULE_06
    .tick   (psc_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // preload storage
  tec_preload_mem u_pre (
    .mclk    (mclk),
    .wr_en   (wr_pre), // RULE_15
    .wr_data (wr_byte),
    .rd_data (preload_rd)
  );

  // reload and readback both use the unreset preload storage

  //////////////////////////////////////////////////////////////////////////////
  // capture sequencer
  wire        cap_mode  = mode == `TEC_MODE_PULSE;
  wire        cap_end   = cap_mode && (cap_q == TEC_CAP_RUN) && cap_stop;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_q <= TEC_CAP_IDLE;
    end else begin
      case (cap_q)
        TEC_CAP_IDLE:  cap_q <= (cap_mode && enable) ? TEC_CAP_ARMED : TEC_CAP_IDLE;
        TEC_CAP_ARMED: begin
          if (!(cap_mode && enable)) cap_q <= TEC_CAP_IDLE;
          else if (cap_start) cap_q <= TEC_CAP_RUN; // RULE_17
        end
        TEC_CAP_RUN: begin
          if (!(cap_mode && enable) || cap_stop) cap_q <= TEC_CAP_IDLE; // RULE_18
        end
        default: cap_q <= TEC_CAP_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // count step
  wire        run_timer = (mode == `TEC_MODE_TIMER) && enable && psc_tick;
  // capture counts only between start and stop, never in the stop cycle
  wire        run_cap   = cap_mode && enable && (cap_q == TEC_CAP_RUN) && !cap_stop && psc_tick;
  wire        run_evt   = (mode == `TEC_MODE_EVENT) && enable && evt_edge; // RULE_07
  wire        step      = run_timer || run_cap || run_evt; // RULE_05 RULE_10
  wire        overflow  = step && (count_q == `TEC_FULL);

  // a preload write in the same cycle as overflow reloads the new value
  wire  [7:0] reload    = wr_pre ? wr_byte : preload_rd;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `TEC_ZERO8;
    end else begin
      if (wr_pre && !enable) count_q <= wr_byte; // RULE_12
      else if (wr_count) count_q <= wr_byte;
      else if (overflow) count_q <= reload; // RULE_11 RULE_13
      else if (step) count_q <= count_q + `TEC_ONE8; // RULE_10
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control register and overflow flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `TEC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wr_byte;
    end else if (cap_end) begin
      ctrl_q[`TEC_EN_BIT] <= 1'b0; // RULE_18
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_q <= 1'b0;
    end else if (overflow) begin
      ovf_flag_q <= 1'b1;
    end else if (wr_stat && wr_byte[0]) begin
      ovf_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
      wake_req  <= 1'b0;
    end else begin
      timer_irq <= overflow; // RULE_11
      wake_req  <= overflow && (mode == `TEC_MODE_EVENT); // RULE_19
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus read and acknowledge
  logic [7:0] rd_byte;

  always_comb begin
    case (wb_adr_i)
      `TEC_OFS_COUNT:   rd_byte = count_q; // RULE_14
      `TEC_OFS_CTRL:    rd_byte = ctrl_q;
      `TEC_OFS_PRELOAD: rd_byte = preload_rd;
      `TEC_OFS_STATUS:  rd_byte = {6'h00, cap_q == TEC_CAP_RUN, ovf_flag_q};
      default:          rd_byte = `TEC_ZERO8;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req && !wb_we_i ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end
endmodule // tec_counter

/* verification/tec_counter_properties.sv */
// port assertions of the event counter
module tec_counter_properties (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        ext_timer_input,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        timer_irq,
  input wire logic        wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       pin_q;
  logic [3:0] quiet_q;
  // cycles since the timer pin last moved, saturating
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_q   <= ext_timer_input;
      quiet_q <= 4'hF;
    end else begin
      pin_q   <= ext_timer_input;
      quiet_q <= (pin_q != ext_timer_input) ? 4'h0 : (quiet_q + {3'h0, quiet_q != 4'hF});
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  dat_write_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
    else $error("read data on write ack");
  irq_reset_a: assert property ($rose(resetn) |-> !timer_irq && !wake_req ##1 !timer_irq)
    else $error("pulse right after reset");
  wake_edge_a: assert property (wake_req |-> quiet_q <= 4'h6)
    else $error("wake without pin transition");
endmodule // tec_counter_properties

/* verification/tec_pin_src.sv */
// pulse source on the timer pin, idle level plus one pulse of given length
module tec_pin_src (
  input wire logic       mclk,
  input wire logic       idle,
  input wire logic       go,
  input wire logic [7:0] width,
  output logic           pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_q = 8'h00;
  always @(posedge mclk) begin
    left_q <= go ? width : left_q - {7'h0, left_q != 8'h00};
  end
  assign pin = (left_q != 8'h00) ? ~idle : idle;
endmodule // tec_pin_src

/* verification/testbench.sv */
// self-checking bench of the event counter
`include "tec_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0, resetn = 1'b0, lsc = 1'b0, pwm = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, idle = 1'b0, go = 1'b0, wk = 1'b0, ack, irq, wake, pin;
  logic [3:0]  adr = 4'h0, sel = 4'hF;
  logic [7:0]  wid = 8'h00, c, p, v;
  logic [31:0] dat = 32'h0, q, rdat, s = 32'h5E;
  int          miscompares = 0, num_checks = 0, ncyc = 0;
  initial forever #20 mclk = ~mclk;
  initial forever begin
    repeat (4) @(posedge mclk);
    lsc <= ~lsc;
  end
  tec_pin_src i_src (.mclk(mclk), .idle(idle), .go(go), .width(wid), .pin(pin));
  tec_counter i_dut (.mclk(mclk), .resetn(resetn), .sys_tick(1'b1),
    .low_speed_crystal_clock(lsc), .pwm_enabled(pwm), .ext_timer_input(pin),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .timer_irq(irq), .wake_req(wake));
  function logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [7:0] nx(input logic [7:0] x);
    return (x == 8'hFF) ? p : x + 8'h01;
  endfunction
  task chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error at %0t: expected %h, got %h", $time, e, g);
      miscompares++;
    end
  endtask
  task xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge mclk iff ack === 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk({24'h0, e}, q);
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task gap(input int e);
    time t;
    @(posedge mclk iff irq === 1'b1);
    t = $time;
    @(posedge mclk iff irq === 1'b1);
    chk(32'(e), 32'(($time - t) / 40));
  endtask
  task end_of_test;
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    ncyc++;
    if (wake) wk <= 1'b1;
    if (ncyc == 40000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    wt(3);
    resetn <= 1'b1;
    wt(3);
    rd(`TEC_OFS_CTRL, `TEC_CTRL_RESET);
    rd(4'h2, 8'h00);
    sel <= 4'h0;
    wr(`TEC_OFS_CTRL, 8'hFF);
    sel <= 4'hF;
    rd(`TEC_OFS_CTRL, `TEC_CTRL_RESET);
    wr(`TEC_OFS_CTRL, 8'h80);
    p = 8'h10;
    wr(`TEC_OFS_PRELOAD, p);
    rd(`TEC_OFS_COUNT, p);
    wr(`TEC_OFS_COUNT, 8'h33);
    wt(20);
    rd(`TEC_OFS_COUNT, 8'h33);
    wr(`TEC_OFS_CTRL, 8'h10);
    wt(20);
    rd(`TEC_OFS_COUNT, 8'h33);
    for (int k = 0; k < 10; k++) begin
      p = {4'hF, 4'(rnd())};
      v = (k < 8) ? 8'h90 | 8'(k) : 8'hB0;
      pwm <= (k == 9);
      wr(`TEC_OFS_CTRL, v & 8'hEF);
      wr(`TEC_OFS_PRELOAD, p);
      wr(`TEC_OFS_CTRL, v);
      gap((256 - p) * ((k == 8) ? 8 : (k < 8) ? (1 << k) : 1));
    end
    wr(`TEC_OFS_CTRL, 8'h87);
    p = 8'hF0;
    wr(`TEC_OFS_PRELOAD, p);
    wr(`TEC_OFS_CTRL, 8'h97);
    wr(`TEC_OFS_PRELOAD, 8'hE0);
    rd(`TEC_OFS_COUNT, 8'hF0);
    gap(32 << 7);
    chk(32'h0, {31'h0, wk});
    rd(`TEC_OFS_STATUS, 8'h01);
    wr(`TEC_OFS_STATUS, 8'h01);
    rd(`TEC_OFS_STATUS, 8'h00);
    for (int e = 0; e < 2; e++) begin
      idle <= 1'b0;
      v = 8'h47 | 8'(e << 3);
      wr(`TEC_OFS_CTRL, v);
      p = 8'hFE;
      wr(`TEC_OFS_PRELOAD, p);
      wr(`TEC_OFS_CTRL, v | 8'h10);
      c = p;
      repeat (2) begin
        idle <= 1'b1;
        wt(6);
        if (e == 0) c = nx(c);
        rd(`TEC_OFS_COUNT, c);
        idle <= 1'b0;
        wt(6);
        if (e == 1) c = nx(c);
        rd(`TEC_OFS_COUNT, c);
      end
    end
    chk(32'h1, {31'h0, wk});
    for (int e = 0; e < 2; e++) begin
      idle <= (e == 0);
      wt(8);
      v = 8'hC0 | 8'(e << 3);
      wr(`TEC_OFS_CTRL, v);
      wr(`TEC_OFS_PRELOAD, 8'h00);
      wr(`TEC_OFS_CTRL, v | 8'h10);
      wt(10);
      rd(`TEC_OFS_COUNT, 8'h00);
      wid <= 8'h14 + 8'(rnd() & 32'h1F);
      go <= 1'b1;
      wt(1);
      go <= 1'b0;
      wt(20);
      rd(`TEC_OFS_STATUS, 8'h03);
      wt(36);
      xfer(1'b0, `TEC_OFS_COUNT, 8'h00);
      chk(32'h1, {31'h0, (q[7:0] + 8'h01 >= wid) && (q[7:0] <= wid + 8'h01)});
      c = q[7:0];
      rd(`TEC_OFS_CTRL, v);
      go <= 1'b1;
      wt(1);
      go <= 1'b0;
      wt(60);
      rd(`TEC_OFS_COUNT, c);
    end
    end_of_test;
  end
endmodule // testbench
bind tec_counter tec_counter_properties i_chk (.mclk(mclk), .resetn(resetn),
  .ext_timer_input(ext_timer_input), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_irq(timer_irq),
  .wake_req(wake_req));
